// ### hdl/async_timer.sv
// timer/counter core with async update path, apb registers, two compare outputs
// assumes osc_input_pin is far slower than sys_clk (under a quarter of its rate)
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module async_timer
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_input_pin,
	output logic compare_out_a,
	output logic compare_out_b,
	output logic compare_oe_a,
	output logic compare_oe_b,
	output logic crystal_osc_enable,
	output logic match_a_event,
	output logic match_b_event,
	output logic overflow_event
);
	// reset leaves two sys_clk edges after release, enters at once; the whole block uses the copy
	logic rs1_r;
	logic rs2_r;
	logic rst_s_n;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rs1_r <= 1'b0;
			rs2_r <= 1'b0;
		end
		else
		begin
			rs1_r <= 1'b1;
			rs2_r <= rs1_r;
		end
	end
	assign rst_s_n = rs2_r;

	// oscillator pin synchroniser and rising-edge detect
	// two stages before any logic: the pin has no phase relation to sys_clk
	logic osc1_r;
	logic osc2_r;
	logic osc3_r;
	logic osc_rise;
	always_ff @(posedge sys_clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			osc1_r <= 1'b0;
			osc2_r <= 1'b0;
			osc3_r <= 1'b0;
		end
		else
		begin
			osc1_r <= osc_input_pin;
			osc2_r <= osc1_r;
			osc3_r <= osc2_r;
		end
	end
	assign osc_rise = osc2_r && !osc3_r;

	// async status bits
	logic external_clock_enable_r, async_r;
	assign crystal_osc_enable = async_r && !external_clock_enable_r;

	// apb decode
	logic wr_en, rd_en;
	logic sel_ca;
	logic sel_cb;
	logic sel_cnt;
	logic sel_oa;
	logic sel_ob;
	logic sel_st;
	logic addr_ok;
	logic [7:0] wbyte;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign sel_ca = paddr == timer_pkg::ctrl_a_addr;
	assign sel_cb = paddr == timer_pkg::ctrl_b_addr;
	assign sel_cnt = paddr == timer_pkg::count_addr;
	assign sel_oa = paddr == timer_pkg::cmp_a_addr;
	assign sel_ob = paddr == timer_pkg::cmp_b_addr;
	assign sel_st = paddr == timer_pkg::status_addr;
	assign addr_ok = sel_ca || sel_cb || sel_cnt || sel_oa || sel_ob || sel_st;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign wbyte = pwdata[7:0];

	// per-register temporary storage, index 0 ctrl b .. 4 count (busy bit order)
	logic [7:0] tmp_r [0:4];
	logic [7:0] dst_r [0:3];
	logic [4:0] busy_r;
	logic [1:0] edge_r [0:4];
	logic [4:0] wsel;
	logic [4:0] land;
	logic [7:0] wmask [0:4];
	assign wsel = {sel_cnt, sel_oa, sel_ob, sel_ca, sel_cb} & {5{wr_en}};
	assign wmask[0] = timer_pkg::ctrl_b_mask;
	assign wmask[1] = timer_pkg::ctrl_a_mask;
	assign wmask[2] = 8'hFF;
	assign wmask[3] = 8'hFF;
	assign wmask[4] = 8'hFF;

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++)
		begin : g_upd
			// sync mode lands at once; async waits two osc edges
			assign land[gi] = async_r ? (busy_r[gi] && osc_rise &&
				edge_r[gi] == 2'(timer_pkg::sync_edges - 1)) : wsel[gi];
			always_ff @(posedge sys_clk or negedge rst_s_n)
			begin
				if (!rst_s_n)
				begin
					tmp_r[gi] <= timer_pkg::reg_reset;
					busy_r[gi] <= 1'b0;
					edge_r[gi] <= 2'h0;
				end
				else if (wsel[gi])
				begin
					tmp_r[gi] <= wbyte & wmask[gi];
					busy_r[gi] <= async_r;
					edge_r[gi] <= 2'h0;
				end
				else if (land[gi] && async_r)
				begin
					busy_r[gi] <= 1'b0;
					edge_r[gi] <= 2'h0;
				end
				else if (busy_r[gi] && osc_rise)
					edge_r[gi] <= edge_r[gi] + 2'h1;
			end
		end
	endgenerate

	// destination copies of control and compare registers
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_dst
			always_ff @(posedge sys_clk or negedge rst_s_n)
			begin
				if (!rst_s_n)
					dst_r[gi] <= timer_pkg::reg_reset;
				else if (land[gi])
					dst_r[gi] <= async_r ? tmp_r[gi] : wbyte & wmask[gi];
			end
		end
	endgenerate
	// the count has no copy here: its destination is the counter itself

	logic [2:0] wgm;
	logic [2:0] cs;
	logic [1:0] com_a, com_b;
	logic non_pwm;
	assign wgm = {dst_r[0][timer_pkg::wgm_hi_bit], dst_r[1][1:0]};
	assign cs = dst_r[0][2:0];
	assign com_a = dst_r[1][timer_pkg::com_a_lsb +: 2];
	assign com_b = dst_r[1][timer_pkg::com_b_lsb +: 2];
	assign non_pwm = wgm == timer_pkg::mode_normal || wgm == timer_pkg::mode_ctc;

	// force strobes act on the write itself, never stored
	logic force_a, force_b;
	assign force_a = wsel[0] && wbyte[timer_pkg::foc_a_bit] && non_pwm;
	assign force_b = wsel[0] && wbyte[timer_pkg::foc_b_bit] && non_pwm;

	// timer clock: io clock or synchronised oscillator
	logic src_tick, tmr_tick;
	assign src_tick = async_r ? osc_rise : 1'b1;
	timer_prescaler u_presc
	(
		.clk(sys_clk),
		.rst_n(rst_s_n),
		.src_tick(src_tick),
		.sel(cs),
		.tick(tmr_tick)
	);

	// counter with up/down for phase-correct modes
	logic [7:0] cnt_r, cnt_nxt;
	logic down_r, down_nxt;
	logic block_r;
	logic [7:0] top;
	logic at_top, ovf;
	logic phase_mode, fast_mode;
	assign top = (wgm == 3'h2 || wgm == 3'h5 || wgm == 3'h7) ? dst_r[3] : timer_pkg::count_max;
	assign at_top = cnt_r == top;
	assign phase_mode = wgm == 3'h1 || wgm == 3'h5;
	assign fast_mode = wgm == 3'h3 || wgm == 3'h7;
	assign ovf = tmr_tick && (phase_mode ? (down_r && cnt_r == 8'h01) : at_top);
	always_comb
	begin
		cnt_nxt = cnt_r + 8'h01;
		down_nxt = down_r;
		if (phase_mode)
		begin
			if (down_r)
			begin
				cnt_nxt = cnt_r - 8'h01;
				down_nxt = cnt_r != 8'h01;
			end
			else if (at_top)
			begin
				cnt_nxt = cnt_r - 8'h01;
				down_nxt = 1'b1;
			end
		end
		else if (at_top)
			cnt_nxt = 8'h00; // only a real match clears in ctc, never a force
	end

	// count write lands through land[4]; blocks match on following tick
	always_ff @(posedge sys_clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			cnt_r <= timer_pkg::reg_reset;
			down_r <= 1'b0;
			block_r <= 1'b0;
		end
		else if (land[4])
		begin
			cnt_r <= async_r ? tmp_r[4] : wbyte;
			block_r <= 1'b1;
		end
		else if (tmr_tick)
		begin
			cnt_r <= cnt_nxt;
			down_r <= down_nxt;
			block_r <= 1'b0;
		end
	end

	// compare match, suppressed for one timer clock after a count write
	logic match_a, match_b;
	assign match_a = tmr_tick && !block_r && cnt_r == dst_r[3];
	assign match_b = tmr_tick && !block_r && cnt_r == dst_r[2];

	// output waveform units
	logic oa_r;
	logic ob_r;
	logic oa_nxt, ob_nxt;
	function automatic logic wave(input logic cur, input logic [1:0] com, input logic np,
		input logic fast, input logic dn, input logic hit, input logic frc, input logic tp);
		logic r;
		r = cur;
		if (np)
		begin
			if (hit || frc)
				r = (com == 2'h1) ? !cur : (com == 2'h2) ? 1'b0 : (com == 2'h3) ? 1'b1 : cur;
		end
		else if (com[1])
		begin
			if (fast && tp)
				r = !com[0];
			else if (hit)
				r = fast ? com[0] : (com[0] ^ dn);
		end
		return r;
	endfunction
	assign oa_nxt = wave(oa_r, com_a, non_pwm, fast_mode, down_r, match_a, force_a,
		ovf);
	assign ob_nxt = wave(ob_r, com_b, non_pwm, fast_mode, down_r, match_b, force_b,
		ovf);
	always_ff @(posedge sys_clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			oa_r <= 1'b0;
			ob_r <= 1'b0;
		end
		else
		begin
			oa_r <= oa_nxt;
			ob_r <= ob_nxt;
		end
	end
	assign compare_out_a = oa_r;
	assign compare_out_b = ob_r;
	assign compare_oe_a = com_a != 2'h0;
	assign compare_oe_b = com_b != 2'h0;
	// match events come only from real matches, so forces raise nothing
	assign match_a_event = match_a;
	assign match_b_event = match_b;
	assign overflow_event = ovf;

	// async control; changing the source leaves timer registers as they are
	always_ff @(posedge sys_clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			external_clock_enable_r <= 1'b0;
			async_r <= 1'b0;
		end
		else if (wr_en && sel_st)
		begin
			external_clock_enable_r <= wbyte[timer_pkg::external_clock_enable_bit];
			async_r <= wbyte[timer_pkg::async_bit];
		end
	end

	// read mux
	logic [7:0] rbyte;
	logic [7:0] rd_r;
	// ctrl and compare temporary storage reads back the last write even before it lands; count reads cnt_r
	always_comb
	begin
		if (sel_cnt)
			rbyte = cnt_r;
		else if (sel_cb)
			rbyte = tmp_r[0];
		else if (sel_ca)
			rbyte = tmp_r[1];
		else if (sel_ob)
			rbyte = tmp_r[2];
		else if (sel_oa)
			rbyte = tmp_r[3];
		else if (sel_st)
			rbyte = {1'b0, external_clock_enable_r, async_r, busy_r};
		else
			rbyte = 8'h00;
	end
	// ctrl b mask drops force and reserved bits
	always_ff @(posedge sys_clk or negedge rst_s_n)
	begin
		if (!rst_s_n)
			rd_r <= 8'h00;
		else if (rd_en && !penable)
			rd_r <= rbyte;
	end
	assign prdata = {24'h000000, rd_r};
endmodule
`default_nettype wire

// ### include/timer_pkg.sv
// timer constants: register map, field positions, reset values, prescaler width
// assumes an apb slave with 32-bit data; registers sit in the low byte of each word
package timer_pkg;
	localparam logic [11:0] ctrl_a_addr = 12'h000;
	localparam logic [11:0] ctrl_b_addr = 12'h004;
	localparam logic [11:0] count_addr = 12'h008;
	localparam logic [11:0] cmp_a_addr = 12'h00C;
	localparam logic [11:0] cmp_b_addr = 12'h010;
	localparam logic [11:0] status_addr = 12'h014;
	localparam int foc_a_bit = 7;
	localparam int foc_b_bit = 6;
	localparam int wgm_hi_bit = 3;
	localparam int com_a_lsb = 6;
	localparam int com_b_lsb = 4;
	localparam int external_clock_enable_bit = 6;
	localparam int async_bit = 5;
	localparam logic [7:0] ctrl_a_mask = 8'hF3;
	localparam logic [7:0] ctrl_b_mask = 8'h0F;
	localparam logic [7:0] reg_reset = 8'h00;
	localparam logic [2:0] mode_normal = 3'h0;
	localparam logic [2:0] mode_ctc = 3'h2;
	localparam logic [7:0] count_max = 8'hFF;
	localparam int sync_edges = 2;
	localparam int presc_width = 10;
endpackage

// ### hdl/timer_prescaler.sv
// prescaler: turns a source tick into the selected count enable
// assumes src_tick is a one-cycle pulse on sys_clk
`timescale 1ns/1ns
`default_nettype none
module timer_prescaler
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic src_tick,
	input wire logic [2:0] sel,
	output logic tick
);
	logic [timer_pkg::presc_width-1:0] cnt_r;
	logic [timer_pkg::presc_width-1:0] cnt_nxt;
	logic tap;
	assign cnt_nxt = cnt_r + 10'h001;
	// taps at /8,/32,/64,/128,/256,/1024: all bits below the tap set
	assign tap = (sel == 3'h1) ? 1'b1 :
		(sel == 3'h2) ? &cnt_r[2:0] :
		(sel == 3'h3) ? &cnt_r[4:0] :
		(sel == 3'h4) ? &cnt_r[5:0] :
		(sel == 3'h5) ? &cnt_r[6:0] :
		(sel == 3'h6) ? &cnt_r[7:0] :
		(sel == 3'h7) ? &cnt_r[9:0] : 1'b0;
	assign tick = src_tick && tap;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 10'h000;
		else if (src_tick)
			cnt_r <= cnt_nxt;
	end
endmodule
`default_nettype wire

// ### dv/async_timer_chk.sv
// port-level properties of async_timer
// assumes bind to async_timer; async_r shadows the async select bit
`timescale 1ns/1ns
`default_nettype none
module async_timer_chk
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic compare_oe_a,
	input wire logic compare_oe_b,
	input wire logic crystal_osc_enable,
	input wire logic match_a_event,
	input wire logic match_b_event
);
	wire wr_on = psel && penable && pwrite;
	wire rd_set = psel && !penable && !pwrite;
	wire st_wr = wr_on && paddr == timer_pkg::status_addr;
	wire cb_wr = wr_on && paddr == timer_pkg::ctrl_b_addr;
	logic async_r;
	logic [2:0] cs_r;
	// shadow only: cs_r is correct only in sync mode, where ctrl b writes land at once
	always_ff @(posedge sys_clk or negedge rst_n)
		if (!rst_n)
			{async_r, cs_r} <= 4'h0;
		else if (st_wr)
			async_r <= pwdata[timer_pkg::async_bit];
		else if (cb_wr)
			cs_r <= pwdata[2:0];
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	a_reset_quiet: assert property (disable iff (1'b0) !rst_n |->
		!compare_oe_a && !crystal_osc_enable && !match_a_event) else $error("reset leak");
	a_ctrlb_rsvd: assert property (rd_set && paddr == timer_pkg::ctrl_b_addr |=>
		prdata[31:4] == 28'h0) else $error("ctrl b high bits");
	a_sync_idle: assert property (rd_set && paddr == timer_pkg::status_addr && !async_r |=>
		prdata[4:0] == 5'h0) else $error("busy in sync mode");
	a_oe_mode: assert property (wr_on && paddr == timer_pkg::ctrl_a_addr && !async_r |=>
		compare_oe_a == |$past(pwdata[7:6]) && compare_oe_b == |$past(pwdata[5:4]))
		else $error("oe mismatch");
	a_osc_enable: assert property (st_wr |=>
		crystal_osc_enable == ($past(pwdata[5]) && !$past(pwdata[6]))) else $error("osc enable");
	a_osc_hold: assert property ($changed(crystal_osc_enable) |-> $past(st_wr))
		else $error("osc enable moved");
	a_force_quiet: assert property (cb_wr && |pwdata[7:6] && !async_r && cs_r == 3'h0
		&& pwdata[2:0] == 3'h0 |=> (!match_a_event && !match_b_event) [*2])
		else $error("force raised event");
	a_map_ok: assert property (psel && penable && paddr == timer_pkg::count_addr |-> !pslverr)
		else $error("count refused");
	cover property (cb_wr && pwdata[7]);
	cover property (match_b_event);
	cover property (wr_on && async_r && paddr == timer_pkg::cmp_b_addr);
endmodule
bind async_timer async_timer_chk u_chk (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pslverr, .compare_oe_a, .compare_oe_b, .crystal_osc_enable,
	.match_a_event, .match_b_event);
`default_nettype wire

// ### dv/test_async_timer.sv
// self-checking apb bench for async_timer
// assumes a zero-wait slave; the osc pin stands still until osc_run
`timescale 1ns/1ns
`default_nettype none
module test_async_timer;
	logic sys_clk, rst_n, psel, penable, pwrite, osc_input_pin, osc_run, e, se, overflow_event;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, v;
	logic pready, pslverr, compare_out_a, compare_out_b, compare_oe_a, compare_oe_b;
	logic crystal_osc_enable, match_a_event, match_b_event;
	int fail_count, num_checks, ev_a, ev_b, ev_o, ca, cb, k;
	int dv[8] = '{4, 1, 8, 32, 64, 128, 256, 1024};
	async_timer DUT (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .osc_input_pin, .compare_out_a, .compare_out_b, .compare_oe_a,
		.compare_oe_b, .crystal_osc_enable, .match_a_event, .match_b_event, .overflow_event);
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		num_checks++;
		if (g !== x)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, x, g);
		end
	endtask
	// one apb transfer; the trailing idle edge lets registered outputs settle
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		do
			@(posedge sys_clk);
		while (pready !== 1'b1);
		v = prdata;
		se = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial
	begin
		osc_input_pin = 1'b0;
		forever #85 if (osc_run) osc_input_pin = ~osc_input_pin;
	end
	always @(posedge sys_clk)
	begin
		ev_a <= ev_a + int'(match_a_event === 1'b1);
		ev_b <= ev_b + int'(match_b_event === 1'b1);
		ev_o <= ev_o + int'(overflow_event === 1'b1);
	end
	initial
	begin
		#1000000;
		fail_count++;
		test_done;
	end
	initial
	begin
		{rst_n, psel, penable, pwrite, osc_run} = 5'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		xfer(0, timer_pkg::status_addr, 0);
		chk("status", 32'h0, v);
		xfer(0, 12'h018, 0);
		chk("unmapped", 32'h0, v);
		chk("pslverr", 32'h1, se);
		xfer(1, timer_pkg::ctrl_b_addr, 8'hF8);
		xfer(0, timer_pkg::ctrl_b_addr, 0);
		chk("ctrl_b", 32'h08, v);
		xfer(1, timer_pkg::ctrl_b_addr, 8'h00);
		ca = ev_a;
		e = 1'b0;
		// set, clear, then toggle twice, so codes 3, 2 and 1 each move the pin
		for (k = 3; k > 0; k--)
		begin
			xfer(1, timer_pkg::ctrl_a_addr, {k[1:0], k[1:0], 4'h0});
			repeat (2)
			begin
				xfer(1, timer_pkg::ctrl_b_addr, 8'hC0);
				e = (k == 3) || (k == 1 && !e);
				chk("out_a", e, compare_out_a);
				chk("out_b", e, compare_out_b);
			end
		end
		xfer(1, timer_pkg::ctrl_a_addr, 8'hF3);
		xfer(1, timer_pkg::ctrl_b_addr, 8'hC0);
		chk("pwm_out_a", 32'h0, compare_out_a);
		xfer(1, timer_pkg::ctrl_b_addr, 8'h00);
		xfer(1, timer_pkg::ctrl_a_addr, 8'h02);
		xfer(1, timer_pkg::cmp_a_addr, 8'h05);
		xfer(1, timer_pkg::count_addr, 8'h05);
		xfer(1, timer_pkg::ctrl_b_addr, 8'hC0);
		xfer(0, timer_pkg::count_addr, 0);
		chk("count", 32'h05, v);
		xfer(1, timer_pkg::ctrl_a_addr, 8'h00);
		xfer(1, timer_pkg::cmp_a_addr, 8'h10);
		xfer(1, timer_pkg::cmp_b_addr, 8'h12);
		xfer(1, timer_pkg::count_addr, 8'h10);
		cb = ev_b;
		xfer(1, timer_pkg::ctrl_b_addr, 8'h01);
		repeat (8) @(posedge sys_clk);
		xfer(1, timer_pkg::ctrl_b_addr, 8'h00);
		chk("ev_a", ca, ev_a);
		chk("ev_b", cb + 1, ev_b);
		for (k = 0; k < 8; k++)
		begin
			xfer(1, timer_pkg::count_addr, 8'h00);
			xfer(1, timer_pkg::ctrl_b_addr, k[7:0]);
			repeat (16 * dv[k]) @(posedge sys_clk);
			xfer(1, timer_pkg::ctrl_b_addr, 8'h00);
			xfer(0, timer_pkg::count_addr, 0);
			chk("count_ok", 32'h1, 32'(k ? (v >= 15 && v <= 20) : v == 0));
		end
		xfer(1, timer_pkg::count_addr, 8'hFE);
		ca = ev_o;
		xfer(1, timer_pkg::ctrl_b_addr, 8'h01);
		repeat (4) @(posedge sys_clk);
		xfer(1, timer_pkg::ctrl_b_addr, 8'h00);
		chk("overflow", ca + 1, ev_o);
		xfer(1, timer_pkg::status_addr, 8'h40);
		xfer(1, timer_pkg::status_addr, 8'h60);
		chk("osc_on", 32'h0, crystal_osc_enable);
		xfer(1, timer_pkg::ctrl_a_addr, 8'h00);
		xfer(1, timer_pkg::ctrl_b_addr, 8'h01);
		xfer(1, timer_pkg::count_addr, 8'h40);
		xfer(1, timer_pkg::cmp_a_addr, 8'h77);
		xfer(1, timer_pkg::cmp_b_addr, 8'h33);
		xfer(0, timer_pkg::status_addr, 0);
		chk("status", 32'h7F, v);
		xfer(0, timer_pkg::cmp_b_addr, 0);
		chk("cmp_b", 32'h33, v);
		osc_run = 1'b1;
		@(posedge osc_input_pin);
		xfer(0, timer_pkg::status_addr, 0);
		chk("status", 32'h7F, v);
		for (k = 0; k < 40 && v[4:0] !== 5'h0; k++)
			xfer(0, timer_pkg::status_addr, 0);
		chk("status", 32'h60, v);
		repeat (20) @(posedge osc_input_pin);
		xfer(0, timer_pkg::count_addr, 0);
		chk("count_live", 32'h1, 32'(v > 32'h48 && v < 32'h60));
		test_done;
	end
endmodule
`default_nettype wire
